// ### haptic_drive_map.svh
// register indexes, field positions, reset values and timing figures
// assumes the includer multiplies an index by four for the byte address
`ifndef HAPTIC_DRIVE_MAP_SVH
`define HAPTIC_DRIVE_MAP_SVH

// ----------------------------------------------------------------------
// register indexes (byte address = index * 4)
// ----------------------------------------------------------------------
`define IDX_TUNE_CTRL       6'h22
`define IDX_PERIOD_LOW      6'h23
`define IDX_PERIOD_HIGH     6'h24
`define IDX_MODE_CTRL       6'h2A
`define IDX_DRIVE_STATUS    6'h2B
`define IDX_OD_AMPLITUDE    6'h30
`define IDX_OD_DURATION     6'h31
`define IDX_DRV_AMPLITUDE   6'h32
`define IDX_DRV_DURATION    6'h33
`define IDX_BRK_AMPLITUDE   6'h34
`define IDX_BRK_DURATION    6'h35

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_TUNE_LAUNCH     0
`define BIT_TUNE_LOCK_OK    1
`define BIT_TRIGGER_MODE    0
`define BIT_AMP_SIGN        7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_BYTE            8'h00
`define RST_PERIOD          12'h000

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_FREQ_KHZ        25000
`define STEP_TIME_US        5000
`define DRIVE_STEP_MULT     2
`define TUNE_LIMIT_MS       1000
`define STEP_CYCLES         (`STEP_TIME_US * `CLK_FREQ_KHZ / 1000)
`define TUNE_LIMIT_CYCLES   (`TUNE_LIMIT_MS * `CLK_FREQ_KHZ)

`endif

// ### haptic_drive_pkg.sv
// types shared by the haptic drive block
// assumes haptic_drive_map.svh carries the register, bus and timing constants
package haptic_drive_pkg;

    typedef enum logic [3:0] {
        PH_IDLE  = 4'h1,
        PH_OVER  = 4'h2,
        PH_DRIVE = 4'h4,
        PH_BRAKE = 4'h8
    } phase_t;

    typedef logic [7:0] reg_byte_t;
    typedef logic [11:0] period_t;

endpackage

// ### tick_divider.sv
// divider giving a one-cycle step pulse every CYCLES clocks
// assumes restart is raised in the last cycle before a new timed phase begins
`timescale 1ns/100ps
`default_nettype none

module tick_divider #(
    parameter int unsigned CYCLES = 125000
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic restart,
    output logic tick
);

    localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

    logic [W-1:0] cnt_r;

    // restart only clears the count; gating tick with it would close a
    // combinational loop through the phase logic that consumes tick
    assign tick = (cnt_r == W'(CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
        end else if (restart || tick) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        tick |=> !tick) else $error("step pulses back to back");

endmodule

`default_nettype wire

// ### tune_engine.sv
// resonance auto-tune: watches back-emf period samples until they settle
// assumes the detector delivers periods in units of 64 reference clocks
`timescale 1ns/100ps
`default_nettype none
`include "haptic_drive_map.svh"

module tune_engine
    import haptic_drive_pkg::*;
#(
    parameter int unsigned LOCK_RUNS = 8,
    parameter int unsigned LOCK_TOL = 2,
    parameter int unsigned TIMEOUT = 25000000
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // command
    input wire logic start,
    // back-emf detector
    input wire logic sample_stb,
    input wire period_t sample_val,
    // result
    output logic busy,
    output logic done,
    output logic lock_ok,
    output period_t period
);

    logic busy_r, done_r, ok_r, have_r;
    period_t last_r, period_r;
    logic [7:0] run_r;
    logic [31:0] tmo_r;
    logic near, locked, expired;
    period_t diff;

    assign diff = (sample_val > last_r) ? sample_val - last_r :
                                          last_r - sample_val;
    assign near = have_r && (32'(diff) <= LOCK_TOL);
    assign locked = busy_r && sample_stb && near &&
                    (32'(run_r) + 32'd2 >= LOCK_RUNS);
    assign expired = busy_r && (tmo_r == TIMEOUT - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            ok_r <= 1'b0;
            have_r <= 1'b0;
            last_r <= `RST_PERIOD;
            period_r <= `RST_PERIOD;
            run_r <= 8'h00;
            tmo_r <= 32'h0;
        end else begin
            done_r <= 1'b0;
            if (start && !busy_r) begin
                busy_r <= 1'b1;
                have_r <= 1'b0;
                run_r <= 8'h00;
                tmo_r <= 32'h0;
            end else if (busy_r) begin
                tmo_r <= tmo_r + 32'd1;
                if (sample_stb) begin
                    last_r <= sample_val;
                    have_r <= 1'b1;
                    run_r <= near ? run_r + 8'h01 : 8'h00;
                end
                // lock wins over the timeout when both land together
                if (locked || expired) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    ok_r <= locked;
                    period_r <= locked ? sample_val : last_r;
                end
            end
        end
    end

    assign busy = busy_r;
    assign done = done_r;
    assign lock_ok = ok_r;
    assign period = period_r;

    a_lock_result: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (busy_r && (locked || expired)) |=>
            (done && lock_ok == $past(locked)))
        else $error("lock flag does not match outcome");
    a_period_result: assert property (
        @(posedge aclk) disable iff (!aresetn)
        locked |=> period == $past(sample_val))
        else $error("locked period not captured");

endmodule

`default_nettype wire

// ### haptic_autotune_trigger_drive.sv
// haptic actuator drive: auto-tune command and external-trigger sequence
// assumes an AXI4-Lite master and a back-emf detector on the same clock
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "haptic_drive_map.svh"

module haptic_autotune_trigger_drive
    import haptic_drive_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = `STEP_CYCLES,
    parameter int unsigned TUNE_LIMIT = `TUNE_LIMIT_CYCLES,
    parameter int unsigned LOCK_RUNS = 8,
    parameter int unsigned LOCK_TOL = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // trigger and back-emf detector
    input wire logic ext_trigger,
    input wire logic bemf_period_stb,
    input wire period_t bemf_period_val,
    // output amplitude path
    output reg_byte_t drive_level,
    output logic drive_active,
    output logic drive_braking,
    output logic tune_active
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic reg_mapped(input logic [7:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        reg_mapped = 1'b0;
        if (addr[1:0] == 2'h0) begin
            case (idx)
                `IDX_TUNE_CTRL, `IDX_PERIOD_LOW, `IDX_PERIOD_HIGH,
                `IDX_MODE_CTRL, `IDX_DRIVE_STATUS,
                `IDX_OD_AMPLITUDE, `IDX_OD_DURATION,
                `IDX_DRV_AMPLITUDE, `IDX_DRV_DURATION,
                `IDX_BRK_AMPLITUDE, `IDX_BRK_DURATION: reg_mapped = 1'b1;
                default: reg_mapped = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // registers and shared state
    // ------------------------------------------------------------------
    reg_byte_t od_amp_r, od_dur_r, drv_amp_r, drv_dur_r;
    reg_byte_t brk_amp_r, brk_dur_r;
    logic mode_en_r, launch_r;
    logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic wlane_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic wr_fire, wr_tune_one;
    logic [5:0] wr_idx;
    logic tune_start, tune_busy, tune_done, tune_ok;
    period_t tune_period;
    phase_t phase_r, phase_nxt;
    logic step, phase_change, trig_d_r, trig_edge, seq_run;
    logic [8:0] steps_left_r;
    reg_byte_t od_snap_r, drv_snap_r, brk_snap_r;
    reg_byte_t src_od, src_drv, src_brk;
    reg_byte_t level_r;
    logic [31:0] phase_cyc_r;

    // ------------------------------------------------------------------
    // axi4-lite write channel: address and data taken in either order
    // ------------------------------------------------------------------
    assign awready = !aw_hold_r;
    assign wready = !w_hold_r;
    assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_idx = awaddr_r[7:2];
    // misaligned or unmapped writes answer SLVERR and must change nothing
    assign wr_tune_one = wr_fire && wlane_r && reg_mapped(awaddr_r) &&
                         (wr_idx == `IDX_TUNE_CTRL) &&
                         wbyte_r[`BIT_TUNE_LAUNCH];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
            awaddr_r <= 8'h00;
            wbyte_r <= `RST_BYTE;
            wlane_r <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold_r <= 1'b1;
                wbyte_r <= wdata[7:0];
                wlane_r <= wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= reg_mapped(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    // only byte lane 0 carries register data; other lanes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            od_amp_r <= `RST_BYTE;
            od_dur_r <= `RST_BYTE;
            drv_amp_r <= `RST_BYTE;
            drv_dur_r <= `RST_BYTE;
            brk_amp_r <= `RST_BYTE;
            brk_dur_r <= `RST_BYTE;
            mode_en_r <= 1'b0;
        end else if (wr_fire && wlane_r && reg_mapped(awaddr_r)) begin
            case (wr_idx)
                `IDX_OD_AMPLITUDE: od_amp_r <= wbyte_r;
                `IDX_OD_DURATION: od_dur_r <= wbyte_r;
                `IDX_DRV_AMPLITUDE: drv_amp_r <= wbyte_r;
                `IDX_DRV_DURATION: drv_dur_r <= wbyte_r;
                `IDX_BRK_AMPLITUDE: brk_amp_r <= wbyte_r;
                `IDX_BRK_DURATION: brk_dur_r <= wbyte_r;
                `IDX_MODE_CTRL: mode_en_r <= wbyte_r[`BIT_TRIGGER_MODE];
                default: mode_en_r <= mode_en_r;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // auto-tune command
    // ------------------------------------------------------------------
    // a second launch while running is ignored; zero writes cannot abort
    assign tune_start = wr_tune_one && !launch_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            launch_r <= 1'b0;
        end else if (tune_start) begin
            launch_r <= 1'b1;
        end else if (tune_done) begin
            launch_r <= 1'b0;
        end
    end

    tune_engine #(
        .LOCK_RUNS(LOCK_RUNS),
        .LOCK_TOL(LOCK_TOL),
        .TIMEOUT(TUNE_LIMIT)
    ) u_tune (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(tune_start),
        .sample_stb(bemf_period_stb),
        .sample_val(bemf_period_val),
        .busy(tune_busy),
        .done(tune_done),
        .lock_ok(tune_ok),
        .period(tune_period)
    );

    assign tune_active = tune_busy;

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    assign arready = !rvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= reg_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (araddr[7:2])
                `IDX_TUNE_CTRL: rdata_r <= {30'h0, tune_ok, launch_r};
                `IDX_PERIOD_LOW: rdata_r <= {24'h0, tune_period[7:0]};
                `IDX_PERIOD_HIGH: rdata_r <= {28'h0, tune_period[11:8]};
                `IDX_MODE_CTRL: rdata_r <= {31'h0, mode_en_r};
                `IDX_DRIVE_STATUS: rdata_r <= {28'h0, phase_r};
                `IDX_OD_AMPLITUDE: rdata_r <= {24'h0, od_amp_r};
                `IDX_OD_DURATION: rdata_r <= {24'h0, od_dur_r};
                `IDX_DRV_AMPLITUDE: rdata_r <= {24'h0, drv_amp_r};
                `IDX_DRV_DURATION: rdata_r <= {24'h0, drv_dur_r};
                `IDX_BRK_AMPLITUDE: rdata_r <= {24'h0, brk_amp_r};
                `IDX_BRK_DURATION: rdata_r <= {24'h0, brk_dur_r};
                default: rdata_r <= 32'h0;
            endcase
            if (araddr[1:0] != 2'h0) begin
                rdata_r <= 32'h0;
            end
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // ------------------------------------------------------------------
    // external-trigger sequence
    // ------------------------------------------------------------------
    // first timed phase after 'from'; zero-length phases are skipped
    function automatic phase_t next_phase(input phase_t from,
        input reg_byte_t od, input reg_byte_t drv, input reg_byte_t brk);
        next_phase = PH_IDLE;
        case (from)
            PH_IDLE: begin
                if (od != 8'h00) next_phase = PH_OVER;
                else if (drv != 8'h00) next_phase = PH_DRIVE;
                else if (brk != 8'h00) next_phase = PH_BRAKE;
            end
            PH_OVER: begin
                if (drv != 8'h00) next_phase = PH_DRIVE;
                else if (brk != 8'h00) next_phase = PH_BRAKE;
            end
            PH_DRIVE: begin
                if (brk != 8'h00) next_phase = PH_BRAKE;
            end
            default: next_phase = PH_IDLE;
        endcase
    endfunction

    assign trig_edge = ext_trigger && !trig_d_r;
    assign seq_run = mode_en_r && !tune_busy;
    // durations are frozen at the trigger so a rewrite cannot stretch a phase
    assign src_od = (phase_r == PH_IDLE) ? od_dur_r : od_snap_r;
    assign src_drv = (phase_r == PH_IDLE) ? drv_dur_r : drv_snap_r;
    assign src_brk = (phase_r == PH_IDLE) ? brk_dur_r : brk_snap_r;
    assign phase_change = (phase_nxt != phase_r);

    always_comb begin
        phase_nxt = phase_r;
        if (!seq_run) begin
            phase_nxt = PH_IDLE;
        end else begin
            case (phase_r)
                PH_IDLE: begin
                    if (trig_edge) begin
                        phase_nxt = next_phase(PH_IDLE, src_od, src_drv,
                                               src_brk);
                    end
                end
                PH_OVER, PH_DRIVE, PH_BRAKE: begin
                    if (step && steps_left_r == 9'h001) begin
                        phase_nxt = next_phase(phase_r, src_od, src_drv,
                                               src_brk);
                    end
                end
                default: phase_nxt = PH_IDLE;
            endcase
        end
    end

    tick_divider #(
        .CYCLES(STEP_CYCLES)
    ) u_step (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(phase_change),
        .tick(step)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= PH_IDLE;
            trig_d_r <= 1'b0;
            steps_left_r <= 9'h000;
            od_snap_r <= `RST_BYTE;
            drv_snap_r <= `RST_BYTE;
            brk_snap_r <= `RST_BYTE;
        end else begin
            phase_r <= phase_nxt;
            trig_d_r <= ext_trigger;
            if (phase_r == PH_IDLE) begin
                od_snap_r <= od_dur_r;
                drv_snap_r <= drv_dur_r;
                brk_snap_r <= brk_dur_r;
            end
            case (phase_nxt)
                PH_OVER: if (phase_change) steps_left_r <= {1'b0, src_od};
                PH_DRIVE: if (phase_change) steps_left_r <= {src_drv, 1'b0};
                PH_BRAKE: if (phase_change) steps_left_r <= {1'b0, src_brk};
                default: steps_left_r <= 9'h000;
            endcase
            if (!phase_change && step) begin
                steps_left_r <= steps_left_r - 9'h001;
            end
        end
    end

    // amplitude follows the phase; the sign bit is passed as written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_r <= `RST_BYTE;
            drive_active <= 1'b0;
            drive_braking <= 1'b0;
        end else begin
            case (phase_nxt)
                PH_OVER: level_r <= od_amp_r;
                PH_DRIVE: level_r <= drv_amp_r;
                PH_BRAKE: level_r <= brk_amp_r;
                default: level_r <= `RST_BYTE;
            endcase
            drive_active <= (phase_nxt != PH_IDLE);
            drive_braking <= (phase_nxt == PH_BRAKE);
        end
    end

    assign drive_level = level_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || phase_change) phase_cyc_r <= 32'h0;
        else phase_cyc_r <= phase_cyc_r + 32'd1;
    end

    sequence s_leave(phase_t ph);
        phase_r == ph && seq_run && step && steps_left_r == 9'h001;
    endsequence

    a_tune_launch: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_tune_one && !launch_r) |=> (launch_r && tune_busy))
        else $error("launch write did not start auto-tune");
    // busy drops with done; a relaunch may follow the cleared bit at once
    a_launch_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tune_done |-> !tune_busy ##1 !launch_r)
        else $error("launch bit not cleared at completion");
    a_od_level: assert property (
        @(posedge aclk) disable iff (!aresetn)
        phase_r == PH_OVER |-> level_r == $past(od_amp_r))
        else $error("overdrive amplitude wrong");
    a_drive_level: assert property (
        @(posedge aclk) disable iff (!aresetn)
        phase_r == PH_DRIVE |-> level_r == $past(drv_amp_r))
        else $error("drive amplitude wrong");
    a_brake_level: assert property (
        @(posedge aclk) disable iff (!aresetn)
        phase_r == PH_BRAKE |->
            (level_r == $past(brk_amp_r) && drive_braking))
        else $error("brake amplitude wrong");
    a_od_length: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_leave(PH_OVER) |-> phase_cyc_r + 32'd1 == od_snap_r * STEP_CYCLES)
        else $error("overdrive length wrong");
    a_drive_length: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_leave(PH_DRIVE) |->
            phase_cyc_r + 32'd1 == drv_snap_r * STEP_CYCLES * 2)
        else $error("drive length wrong");
    a_od_then_drive: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_leave(PH_OVER) ##1 (drv_snap_r != 8'h00) |-> phase_r == PH_DRIVE)
        else $error("normal drive did not follow overdrive");
    a_period_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && araddr == {`IDX_PERIOD_HIGH, 2'h0}) |=>
            rdata == {28'h0, $past(tune_period[11:8])})
        else $error("period high nibble misread");

endmodule

`default_nettype wire

// ### actuator_model.sv
// actuator stand-in: back-emf period samples while auto-tune runs
// assumes tune_active from the block and a wobble select from the bench
`timescale 1ns/100ps
`default_nettype none

module actuator_model
    import haptic_drive_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic tune_active,
    input wire logic wobble,
    // detector side
    output logic bemf_period_stb,
    output period_t bemf_period_val
);
    logic [2:0] cnt_r;
    logic flip_r;
    period_t smp;
    // a wobbling actuator never settles, so locking must fail
    assign smp = (wobble && flip_r) ? 12'h5B3 : 12'h5A3;
    always_ff @(posedge aclk) begin
        if (!aresetn || !tune_active) begin
            cnt_r <= 3'h0;
            flip_r <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == 3'h4) ? 3'h0 : cnt_r + 3'h1;
            flip_r <= (cnt_r == 3'h4) ? !flip_r : flip_r;
        end
    end
    // value off the strobe is scrambled, never the last sample
    assign bemf_period_stb = tune_active && (cnt_r == 3'h4);
    assign bemf_period_val = bemf_period_stb ? smp : ~smp;
endmodule
`default_nettype wire

// ### haptic_autotune_trigger_drive_tb.sv
// self-checking bench for the haptic drive block
// assumes the design files and the actuator model compile first
`timescale 1ns/100ps
`default_nettype none
`include "haptic_drive_map.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end

module haptic_autotune_trigger_drive_tb;
    import haptic_drive_pkg::*;
    typedef struct {logic [5:0] i; reg_byte_t w, r; logic [1:0] s;} row_t;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, ext_trigger = 0, wobble = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, stb, drive_active;
    logic drive_braking, tune_active;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata;
    period_t pval;
    reg_byte_t drive_level, rv;
    int n_fail = 0, compares = 0, cyc = 0, n_od, n_dr, nb, bad;
    row_t rows[8] = '{'{`IDX_OD_AMPLITUDE, 8'h45, 8'h45, `RESP_OKAY},
        '{`IDX_OD_DURATION, 8'hFF, 8'hFF, `RESP_OKAY},
        '{`IDX_DRV_AMPLITUDE, 8'h7F, 8'h7F, `RESP_OKAY},
        '{`IDX_DRV_DURATION, 8'h01, 8'h01, `RESP_OKAY},
        '{`IDX_PERIOD_LOW, 8'hFF, 8'h00, `RESP_OKAY},
        '{`IDX_BRK_AMPLITUDE, 8'h33, 8'h33, `RESP_OKAY},
        '{`IDX_BRK_DURATION, 8'h01, 8'h01, `RESP_OKAY},
        '{6'h3F, 8'h11, 8'h00, `RESP_SLVERR}};

    haptic_autotune_trigger_drive #(.STEP_CYCLES(4), .TUNE_LIMIT(200))
        haptic_autotune_trigger_drive_i (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .ext_trigger(ext_trigger),
        .bemf_period_stb(stb), .bemf_period_val(pval),
        .drive_level(drive_level), .drive_active(drive_active),
        .drive_braking(drive_braking), .tune_active(tune_active));
    actuator_model actuator_model_i (.aclk(aclk), .aresetn(aresetn),
        .tune_active(tune_active), .wobble(wobble),
        .bemf_period_stb(stb), .bemf_period_val(pval));

    always #20 aclk = !aclk;

    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // the watchdog is the only thing that ends a bus wait
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic wr(input logic [5:0] i, input reg_byte_t d);
        @(posedge aclk);
        awaddr <= {i, 2'b00};
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] i);
        @(posedge aclk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdata[7:0];
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic tune(input logic wb, input reg_byte_t ex);
        wobble <= wb;
        wr(`IDX_TUNE_CTRL, 8'h01);
        @(posedge aclk);
        `CHK("tune_active", 1'b1, tune_active)
        do rd(`IDX_TUNE_CTRL); while (rv[0] !== 1'b0);
        `CHK("tune_ctrl", ex, rv)
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[k]) begin
            rd(rows[k].i);
            `CHK("reset", `RST_BYTE, rv)
            wr(rows[k].i, rows[k].w);
            `CHK("wresp", rows[k].s, rs)
            rd(rows[k].i);
            `CHK("rdata", rows[k].r, rv)
            `CHK("rresp", rows[k].s, rs)
        end
        tune(1'b0, 8'h02);
        rd(`IDX_PERIOD_LOW);
        `CHK("period_low", 8'hA3, rv)
        rd(`IDX_PERIOD_HIGH);
        `CHK("period_high", 8'h05, rv)
        tune(1'b1, 8'h00);
        wr(`IDX_OD_DURATION, 8'h02);
        wr(`IDX_MODE_CTRL, 8'h01);
        ext_trigger <= 1'b1;
        {n_od, n_dr, nb, bad} = '0;
        repeat (40) begin
            @(posedge aclk);
            if (drive_level === 8'h45) n_od++;
            if (drive_level === 8'h7F) n_dr++;
            if (drive_level === 8'h7F && n_od != 8) bad++;
            if (drive_braking === 1'b1 && drive_level === 8'h33) nb++;
        end
        `CHK("od_cycles", 8, n_od)
        `CHK("drive_cycles", 8, n_dr)
        `CHK("order", 0, bad)
        `CHK("brake_cycles", 4, nb)
        `CHK("idle", 1'b0, drive_active)
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`IDX_PERIOD_LOW);
        `CHK("period_reset", 8'h00, rv)
        final_report();
    end
endmodule
`default_nettype wire
